/* File: pwli_interp.sv */
// Piecewise-linear function evaluator working over a word-wide operand memory.
// Assumes a read returns data in the same cycle as memRdEn and the caller holds
// the three base addresses valid in the start cycle, when they are latched.
`timescale 1ns/1ps
module pwli_interp
   import pwli_pkg::*;
#(
   parameter int AW = 16
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic piecewiseFunctionOp,
   input wire logic [AW-1:0] tableBase,
   input wire logic [AW-1:0] inputOperand,
   input wire logic [AW-1:0] resultBase,
   output logic memRdEn,
   output logic memWrEn,
   output logic [AW-1:0] memAddr,
   input wire logic [WORD_W-1:0] memRdData,
   output logic [WORD_W-1:0] memWrData,
   output logic busy,
   output logic done,
   output logic dataErrorFlag
);
   localparam int EW = AW + 19;

   pwli_state_type state;
   logic pend, hiHalf, isY, found, interior, divStart, divDone;
   logic [15:0] typeCode, count, lowWord;
   logic [7:0] ptIdx;
   logic [AW-1:0] tabAddr, inAddr, resAddr, rdAddr;
   logic signed [KEY_W-1:0] inKey, curX, prevX, segX0, segX1, yA, yB;
   logic [31:0] prevYRaw, result;

   logic isDword, isSigned, isFloat, typeOk, countBad, overlap, valDone;
   logic orderErr, checkErr, errNow, hitSeg, lastPt, wideRead;
   logic [31:0] fullVal;
   logic signed [KEY_W-1:0] valKey, valExt, dy, di, dx, qSigned, sumRes;
   logic signed [2*KEY_W-1:0] prod;
   logic [2*KEY_W-1:0] mag, quo, qTimesDx, qPlusTimesDx;
   logic [EW-1:0] tabLo, tabHi, inLo, resLo, opLen;

   // ****************************************************************
   // Value conversion.
   // ****************************************************************
   function automatic logic signed [KEY_W-1:0] extOf(input logic [31:0] v, input logic sg, input logic dw);
      if (!dw) begin
         extOf = sg ? {{18{v[15]}}, v[15:0]} : {18'h00000, v[15:0]};
      end else begin
         extOf = sg ? {{2{v[31]}}, v} : {2'h0, v};
      end
   endfunction

   // Floats map to an ordered key so one signed compare serves every type.
   function automatic logic signed [KEY_W-1:0] keyOf(input logic [31:0] v, input logic sg, input logic dw,
                                                   input logic fl);
      if (fl) begin
         keyOf = {2'h0, (v[31] ? ~v : {1'b1, v[30:0]})};
      end else begin
         keyOf = extOf(v, sg, dw);
      end
   endfunction

   // ****************************************************************
   // Decode and checks.
   // ****************************************************************
   assign typeOk = (typeCode == TYPE_U16) || (typeCode == TYPE_S16) || (typeCode == TYPE_U32) ||
                   (typeCode == TYPE_S32) || (typeCode == TYPE_F32);
   assign isDword = (typeCode == TYPE_U32) || (typeCode == TYPE_S32) || (typeCode == TYPE_F32);
   assign isSigned = (typeCode == TYPE_S16) || (typeCode == TYPE_S32);
   assign isFloat = (typeCode == TYPE_F32);
   assign countBad = (count < MIN_POINTS) || (count > MAX_POINTS);

   assign opLen = isDword ? EW'(WORDS_DOUBLE) : EW'(WORDS_SINGLE);
   assign tabLo = EW'(tabAddr);
   assign inLo = EW'(inAddr);
   assign resLo = EW'(resAddr);
   assign tabHi = tabLo + EW'(OFS_POINTS) + EW'(count) * EW'(VALS_PER_POINT) * opLen;
   assign overlap = ((inLo < tabHi) && (tabLo < inLo + opLen)) ||
                    ((resLo < tabHi) && (tabLo < resLo + opLen));

   // Header words are always single; operands are double for 32-bit types.
   assign wideRead = isDword && ((state == ST_INPUT) || (state == ST_POINT));
   assign valDone = pend && (!wideRead || hiHalf);
   assign fullVal = wideRead ? {memRdData, lowWord} : {16'h0000, memRdData};
   assign valKey = keyOf(fullVal, isSigned, isDword, isFloat);
   assign valExt = extOf(fullVal, isSigned, isDword);

   assign checkErr = (state == ST_CHECK) && (!typeOk || countBad || overlap);
   assign orderErr = (state == ST_POINT) && valDone && !isY && (ptIdx != 8'h00) && (valKey <= prevX);
   assign errNow = checkErr || orderErr;
   assign lastPt = ptIdx == (count[7:0] - 8'h01);
   assign hitSeg = !found && (ptIdx != 8'h00) && (inKey < curX);

   // ****************************************************************
   // Segment arithmetic.
   // ****************************************************************
   assign dy = yB - yA;
   assign di = inKey - segX0;
   assign dx = segX1 - segX0;
   assign prod = dy * di;
   assign mag = prod[2*KEY_W-1] ? $unsigned(-prod) : $unsigned(prod);
   assign qSigned = dy[KEY_W-1] ? -$signed(quo[KEY_W-1:0]) : $signed(quo[KEY_W-1:0]);
   assign sumRes = yA + qSigned;
   assign qTimesDx = {{KEY_W{1'b0}}, quo[KEY_W-1:0]} * {{KEY_W{1'b0}}, dx};
   assign qPlusTimesDx = qTimesDx + {{KEY_W{1'b0}}, dx};

   pwli_divider #(.NUM_W(2 * KEY_W), .DEN_W(KEY_W)) u_div (
      .ref_clk(ref_clk),
      .srst(srst),
      .start(divStart),
      .dividend(mag),
      .divisor(dx),
      .finish(divDone),
      .quotient(quo)
   );

   // ****************************************************************
   // Sequencer and memory port.
   // ****************************************************************
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state <= ST_IDLE;
         memRdEn <= 1'b0;
         memWrEn <= 1'b0;
         memAddr <= '0;
         memWrData <= '0;
         busy <= 1'b0;
         done <= 1'b0;
         pend <= 1'b0;
         hiHalf <= 1'b0;
         isY <= 1'b0;
         found <= 1'b0;
         interior <= 1'b0;
         divStart <= 1'b0;
         typeCode <= '0;
         count <= '0;
         lowWord <= '0;
         ptIdx <= '0;
         tabAddr <= '0;
         inAddr <= '0;
         resAddr <= '0;
         rdAddr <= '0;
         inKey <= '0;
         curX <= '0;
         prevX <= '0;
         segX0 <= '0;
         segX1 <= '0;
         yA <= '0;
         yB <= '0;
         prevYRaw <= '0;
         result <= '0;
      end else begin
         memRdEn <= 1'b0;
         memWrEn <= 1'b0;
         done <= 1'b0;
         divStart <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (piecewiseFunctionOp) begin
                  tabAddr <= tableBase;
                  inAddr <= inputOperand;
                  resAddr <= resultBase;
                  rdAddr <= tableBase;
                  busy <= 1'b1;
                  found <= 1'b0;
                  interior <= 1'b0;
                  ptIdx <= '0;
                  isY <= 1'b0;
                  hiHalf <= 1'b0;
                  pend <= 1'b0;
                  state <= ST_TYPE;
               end
            end
            ST_TYPE, ST_COUNT, ST_INPUT, ST_POINT: begin
               if (!pend) begin
                  memRdEn <= 1'b1;
                  memAddr <= rdAddr;
                  rdAddr <= rdAddr + 1'b1;
                  pend <= 1'b1;
               end else if (!valDone) begin
                  pend <= 1'b0;
                  hiHalf <= 1'b1;
                  lowWord <= memRdData;
               end else begin
                  pend <= 1'b0;
                  hiHalf <= 1'b0;
                  if (state == ST_TYPE) begin
                     typeCode <= memRdData;
                     state <= ST_COUNT;
                  end else if (state == ST_COUNT) begin
                     count <= memRdData;
                     state <= ST_CHECK;
                  end else if (state == ST_INPUT) begin
                     inKey <= valKey;
                     rdAddr <= tabAddr + AW'(OFS_POINTS);
                     state <= ST_POINT;
                  end else if (!isY) begin
                     if (orderErr) begin
                        state <= ST_DONE;
                     end else begin
                        curX <= valKey;
                        isY <= 1'b1;
                     end
                  end else begin
                     isY <= 1'b0;
                     ptIdx <= ptIdx + 8'h01;
                     prevX <= curX;
                     prevYRaw <= fullVal;
                     if (!found && (ptIdx == 8'h00) && (inKey < curX)) begin
                        found <= 1'b1;
                        result <= fullVal;
                     end else if (hitSeg) begin
                        found <= 1'b1;
                        interior <= 1'b1;
                        segX0 <= prevX;
                        segX1 <= curX;
                        yA <= extOf(prevYRaw, isSigned, isDword);
                        yB <= valExt;
                        result <= prevYRaw;
                     end
                     if (lastPt) begin
                        if (!found && !(inKey < curX)) begin
                           result <= fullVal;
                        end
                        if ((interior || hitSeg) && !isFloat) begin
                           divStart <= 1'b1;
                           state <= ST_DIV;
                        end else begin
                           state <= ST_WRITE;
                        end
                     end
                  end
               end
            end
            ST_CHECK: begin
               if (checkErr) begin
                  state <= ST_DONE;
               end else begin
                  rdAddr <= inAddr;
                  state <= ST_INPUT;
               end
            end
            ST_DIV: begin
               if (divDone) begin
                  result <= sumRes[31:0];
                  state <= ST_WRITE;
               end
            end
            ST_WRITE: begin
               memWrEn <= 1'b1;
               if (!hiHalf) begin
                  memAddr <= resAddr;
                  memWrData <= result[15:0];
                  hiHalf <= isDword;
                  state <= isDword ? ST_WRITE : ST_DONE;
               end else begin
                  memAddr <= resAddr + 1'b1;
                  memWrData <= result[31:16];
                  hiHalf <= 1'b0;
                  state <= ST_DONE;
               end
            end
            ST_DONE: begin
               done <= 1'b1;
               busy <= 1'b0;
               state <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ****************************************************************
   // Data error flag, held until the next accepted start.
   // ****************************************************************
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         dataErrorFlag <= 1'b0;
      end else if (errNow) begin
         dataErrorFlag <= 1'b1;
      end else if ((state == ST_IDLE) && piecewiseFunctionOp) begin
         dataErrorFlag <= 1'b0;
      end
   end

   // ****************************************************************
   // Checks.
   // ****************************************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   property p_type_err;
      (state == ST_CHECK) && !typeOk |=> (dataErrorFlag && state == ST_DONE) ##1 done;
   endproperty
   a_type_err: assert property (p_type_err) else $error("bad type code not flagged");

   property p_count_err;
      (state == ST_CHECK) && typeOk && ((count < MIN_POINTS) || (count > MAX_POINTS))
         |=> dataErrorFlag ##1 (done && !memWrEn);
   endproperty
   a_count_err: assert property (p_count_err) else $error("bad point count not flagged");

   property p_no_write_on_err;
      dataErrorFlag |-> !memWrEn;
   endproperty
   a_no_write_on_err: assert property (p_no_write_on_err) else $error("result written after data error");

   property p_low_clamp;
      (state == ST_POINT) && isY && valDone && (ptIdx == 8'h00) && (inKey < curX)
         |=> found && !interior && (result == $past(fullVal));
   endproperty
   a_low_clamp: assert property (p_low_clamp) else $error("low clamp did not return first Y");

   property p_segment;
      (state == ST_DIV) |-> (segX0 <= inKey) && (inKey < segX1) && (dx > 0);
   endproperty
   a_segment: assert property (p_segment) else $error("chosen segment does not hold the input");

   property p_high_clamp;
      (state == ST_POINT) && isY && valDone && lastPt && !found && !(inKey < curX)
         |=> (state == ST_WRITE) && (result == $past(fullVal));
   endproperty
   a_high_clamp: assert property (p_high_clamp) else $error("high clamp did not return last Y");

   property p_truncate;
      (state == ST_DIV) && divDone |-> (qTimesDx <= mag) && (mag < qPlusTimesDx);
   endproperty
   a_truncate: assert property (p_truncate) else $error("quotient not truncated");

   property p_overlap;
      (state == ST_CHECK) && overlap |=> dataErrorFlag ##1 (done && dataErrorFlag);
   endproperty
   a_overlap: assert property (p_overlap) else $error("area overlap not flagged");

   property p_order;
      orderErr |=> (state == ST_DONE) ##1 (done && dataErrorFlag);
   endproperty
   a_order: assert property (p_order) else $error("unordered X not flagged");

   property p_header;
      (state == ST_IDLE) && piecewiseFunctionOp |=> ##1 (memRdEn && memAddr == tabAddr + AW'(OFS_TYPE))
         ##2 (memRdEn && memAddr == tabAddr + AW'(OFS_COUNT));
   endproperty
   a_header: assert property (p_header) else $error("header words not fetched in order");

   property p_high_word;
      memRdEn && hiHalf |-> memAddr == $past(memAddr, 2) + 1'b1;
   endproperty
   a_high_word: assert property (p_high_word) else $error("high word not at next address");

   property p_done;
      done |-> !busy ##1 (!done && (state == ($past(piecewiseFunctionOp) ? ST_TYPE : ST_IDLE)));
   endproperty
   a_done: assert property (p_done) else $error("done is not a single closing pulse");
endmodule

/* File: pwli_pkg.sv */
// Shared constants and types of the piecewise-linear interpolator.
// Assumes a 16-bit operand memory whose words are addressed one by one.
package pwli_pkg;

   // ****************************************************************
   // Data type codes held in the first word of the table.
   // ****************************************************************
   localparam logic [15:0] TYPE_U16 = 16'h0001;
   localparam logic [15:0] TYPE_S16 = 16'h0002;
   localparam logic [15:0] TYPE_U32 = 16'h0004;
   localparam logic [15:0] TYPE_S32 = 16'h0008;
   localparam logic [15:0] TYPE_F32 = 16'hffff;

   // ****************************************************************
   // Table layout and limits.
   // ****************************************************************
   localparam int OFS_TYPE = 0;
   localparam int OFS_COUNT = 1;
   localparam int OFS_POINTS = 2;
   localparam int VALS_PER_POINT = 2;
   localparam int WORDS_SINGLE = 1;
   localparam int WORDS_DOUBLE = 2;
   localparam logic [15:0] MIN_POINTS = 16'h0002;
   localparam logic [15:0] MAX_POINTS = 16'h00ff;
   localparam int WORD_W = 16;
   localparam int KEY_W = 34;

   // ****************************************************************
   // Sequencer states.
   // ****************************************************************
   typedef enum logic [8:0] {
      ST_IDLE  = 9'h001,
      ST_TYPE  = 9'h002,
      ST_COUNT = 9'h004,
      ST_CHECK = 9'h008,
      ST_INPUT = 9'h010,
      ST_POINT = 9'h020,
      ST_DIV   = 9'h040,
      ST_WRITE = 9'h080,
      ST_DONE  = 9'h100
   } pwli_state_type;

endpackage

/* File: pwli_divider.sv */
// Iterative restoring divider, one quotient bit per clock.
// Assumes start is a one-cycle pulse and the divisor is not zero.
`timescale 1ns/1ps
module pwli_divider #(
   parameter int NUM_W = 68,
   parameter int DEN_W = 34
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic start,
   input wire logic [NUM_W-1:0] dividend,
   input wire logic [DEN_W-1:0] divisor,
   output logic finish,
   output logic [NUM_W-1:0] quotient
);
   localparam int CW = $clog2(NUM_W + 1);

   logic [DEN_W:0] rem;
   logic [DEN_W:0] shifted;
   logic [CW-1:0] cnt;
   logic running;

   assign shifted = {rem[DEN_W-1:0], quotient[NUM_W-1]};

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rem <= '0;
         quotient <= '0;
         cnt <= '0;
         running <= 1'b0;
         finish <= 1'b0;
      end else begin
         finish <= 1'b0;
         if (start) begin
            rem <= '0;
            quotient <= dividend;
            cnt <= CW'(NUM_W);
            running <= 1'b1;
         end else if (running) begin
            if (shifted >= {1'b0, divisor}) begin
               rem <= shifted - {1'b0, divisor};
               quotient <= {quotient[NUM_W-2:0], 1'b1};
            end else begin
               rem <= shifted;
               quotient <= {quotient[NUM_W-2:0], 1'b0};
            end
            cnt <= cnt - 1'b1;
            if (cnt == CW'(1)) begin
               running <= 1'b0;
               finish <= 1'b1;
            end
         end
      end
   end
endmodule

/* File: pwli_mem_model.sv */
// Behavioural operand memory standing on the far side of the interpolator.
// Assumes one clock, reads are never back to back, and addresses stay below 1024.
`timescale 1ns/1ps
module pwli_mem_model
   import pwli_pkg::*;
(
   input wire logic ref_clk,
   input wire logic memRdEn,
   input wire logic memWrEn,
   input wire logic [15:0] memAddr,
   output logic [WORD_W-1:0] memRdData,
   input wire logic [WORD_W-1:0] memWrData
);
   logic [WORD_W-1:0] mem [1024];
   logic [WORD_W-1:0] idleData = 16'h0000;

   // The read answer stands only in the strobe cycle, where the interpolator samples it.
   // Outside that cycle the data toggles, so stale data never looks valid.
   assign memRdData = memRdEn ? mem[memAddr[9:0]] : idleData;

   always @(posedge ref_clk) begin
      idleData <= ~idleData;
      if (memWrEn) begin
         mem[memAddr[9:0]] <= memWrData;
      end
   end
endmodule

/* File: test_piecewise_linear_interpolator.sv */
// Self-checking bench for the interpolator with a behavioural operand memory.
// Assumes pwli_pkg and pwli_mem_model are compiled first.
`timescale 1ns/1ps
module test_piecewise_linear_interpolator
   import pwli_pkg::*;
;
   localparam logic [15:0] TB = 16'h0020;
   logic ref_clk, srst, op;
   logic [15:0] tableBase, inputOperand, resultBase, memAddr, memRdData, memWrData;
   logic memRdEn, memWrEn, busy, done, dataErrorFlag;
   logic signed [71:0] xs [256];
   logic signed [71:0] ys [256];
   logic [15:0] tp;
   int n, w, errorCnt, totalChecks;

   pwli_interp #(.AW(16)) uut (.ref_clk(ref_clk), .srst(srst), .piecewiseFunctionOp(op), .tableBase(tableBase),
      .inputOperand(inputOperand), .resultBase(resultBase), .memRdEn(memRdEn), .memWrEn(memWrEn),
      .memAddr(memAddr), .memRdData(memRdData), .memWrData(memWrData), .busy(busy), .done(done),
      .dataErrorFlag(dataErrorFlag));
   pwli_mem_model mdl (.ref_clk(ref_clk), .memRdEn(memRdEn), .memWrEn(memWrEn), .memAddr(memAddr),
      .memRdData(memRdData), .memWrData(memWrData));

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // ****************************************************************
   // Checking and table helpers.
   // ****************************************************************
   task automatic endSim();
      if (errorCnt == 0 && totalChecks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      totalChecks++;
      if (got !== exp) begin
         errorCnt++;
         $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic put(input logic [15:0] a, input logic [31:0] v);
      mdl.mem[a[9:0]] = v[15:0];
      if (w == 2) begin
         mdl.mem[a[9:0] + 10'h001] = v[31:16];
      end
   endtask

   task automatic pt(input int i, input logic signed [71:0] x, input logic signed [71:0] y);
      xs[i] = x;
      ys[i] = y;
   endtask

   task automatic load(input logic [15:0] cnt);
      mdl.mem[TB[9:0]] = tp;
      mdl.mem[TB[9:0] + 10'h001] = cnt;
      for (int i = 0; i < n; i++) begin
         put(TB + 16'(2 + 2 * i * w), xs[i][31:0]);
         put(TB + 16'(2 + (2 * i + 1) * w), ys[i][31:0]);
      end
   endtask

   // Builds a random strictly increasing table that fits the type's range.
   task automatic gen(input logic [15:0] t, input int cnt);
      longint ymod;
      longint span;
      logic signed [71:0] off;
      tp = t;
      n = cnt;
      w = (t == TYPE_U16 || t == TYPE_S16) ? 1 : 2;
      ymod = (w == 1) ? 64'h10000 : ((t == TYPE_F32) ? 64'h80000000 : 64'h100000000);
      span = ((w == 1) ? 64'h3e80 : 64'h8000000) / n;
      off = (t == TYPE_S16 || t == TYPE_S32) ? 72'(span * n / 2) : 72'sh0;
      for (int i = 0; i < n; i++) begin
         xs[i] = ((i == 0) ? 72'sh1 - off : xs[i-1]) + 72'(longint'($urandom) % span) + 72'sh1;
         ys[i] = 72'(longint'($urandom) % ymod) - ((off != 0) ? 72'(ymod / 2) : 72'sh0);
      end
      load(16'(n));
   endtask

   function automatic logic signed [71:0] pick();
      return xs[0] - 72'sh1 + 72'(longint'($urandom) % longint'(xs[n-1] - xs[0] + 72'sh3));
   endfunction

   function automatic logic [31:0] expectVal(input logic signed [71:0] in);
      logic signed [71:0] r;
      int m;
      m = 0;
      if (in < xs[0]) begin
         r = ys[0];
      end else if (in >= xs[n-1]) begin
         r = ys[n-1];
      end else begin
         while (xs[m+1] <= in) m++;
         r = (tp == TYPE_F32) ? ys[m] : ys[m] + (ys[m+1] - ys[m]) * (in - xs[m]) / (xs[m+1] - xs[m]);
      end
      return (w == 1) ? {16'h0000, r[15:0]} : r[31:0];
   endfunction

   // A second start is raised while busy and must be ignored.
   task automatic run(input logic signed [71:0] in, input logic expErr);
      int k;
      logic [31:0] got;
      logic [31:0] expv;
      mdl.mem[resultBase[9:0]] = 16'h5a5a;
      mdl.mem[resultBase[9:0] + 10'h001] = 16'h5a5a;
      put(inputOperand, in[31:0]);
      expv = expErr ? ((w == 1) ? 32'h00005a5a : 32'h5a5a5a5a) : expectVal(in);
      @(posedge ref_clk);
      #2 op = 1'b1;
      @(posedge ref_clk);
      #2 op = 1'b0;
      repeat (2) @(posedge ref_clk);
      #2 op = 1'b1;
      @(posedge ref_clk);
      #2 op = 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 3000) begin
         @(posedge ref_clk);
         #2 k++;
      end
      if (k == 3000) begin
         errorCnt++;
         endSim();
      end else begin
         got = {(w == 2) ? mdl.mem[resultBase[9:0] + 10'h001] : 16'h0000, mdl.mem[resultBase[9:0]]};
         chk({31'h0, busy}, 32'h0);
         chk({31'h0, dataErrorFlag}, {31'h0, expErr});
         chk(got, expv);
      end
   endtask

   // ****************************************************************
   // Main sequence.
   // ****************************************************************
   initial begin
      logic [15:0] bad [4];
      logic [15:0] good [5];
      bad = '{16'h0000, 16'h0003, 16'h0010, 16'hfffe};
      good = '{TYPE_U16, TYPE_S16, TYPE_U32, TYPE_S32, TYPE_F32};
      errorCnt = 0;
      totalChecks = 0;
      op = 1'b0;
      srst = 1'b1;
      tableBase = TB;
      inputOperand = 16'h0004;
      resultBase = 16'h0008;
      void'($urandom(32'h3106));
      repeat (4) @(posedge ref_clk);
      #2 srst = 1'b0;
      chk({27'h0, busy, done, dataErrorFlag, memRdEn, memWrEn}, 32'h0);
      gen(TYPE_U16, 4);
      pt(0, 72'sh32, 72'shc8);
      pt(1, 72'sh2bc, 72'sh672);
      pt(2, 72'sh4ce, 72'shdde);
      pt(3, 72'sh60e, 72'sh15e0);
      load(16'h0004);
      run(72'sh384, 1'b0);
      run(72'sh31, 1'b0);
      run(72'sh2bc, 1'b0);
      run(72'sh60e, 1'b0);
      gen(TYPE_S32, 4);
      pt(0, -72'sh32, -72'sh12c);
      pt(1, -72'sh19, -72'sh64);
      pt(2, 72'sh0, -72'sh32);
      pt(3, 72'sh32, 72'sh64);
      load(16'h0004);
      run(-72'sh1e, 1'b0);
      run(-72'sh33, 1'b0);
      for (int t = 0; t < 5; t++) begin
         for (int j = 0; j < 6; j++) begin
            gen(good[t], 2 + int'($urandom % 7));
            run(pick(), 1'b0);
         end
      end
      gen(TYPE_U16, 255);
      run(pick(), 1'b0);
      for (int b = 0; b < 4; b++) begin
         gen(TYPE_U16, 3);
         tp = bad[b];
         load(16'h0003);
         run(72'sh5, 1'b1);
         gen(TYPE_U16, 2);
         load((b == 0) ? 16'h0000 : ((b == 1) ? 16'h0001 : 16'h0100));
         run(72'sh5, 1'b1);
      end
      gen(TYPE_U16, 3);
      resultBase = TB + 16'h0007;
      run(pick(), 1'b1);
      gen(TYPE_U16, 3);
      resultBase = TB + 16'h0008;
      run(pick(), 1'b0);
      resultBase = 16'h0008;
      inputOperand = TB + 16'h0004;
      run(72'sh5, 1'b1);
      gen(TYPE_U16, 3);
      inputOperand = TB - 16'h0001;
      run(pick(), 1'b0);
      gen(TYPE_U32, 2);
      // The input's high word lands on the type word and rewrites it with the same code.
      run(72'sh40005, 1'b1);
      inputOperand = 16'h0004;
      gen(TYPE_S16, 4);
      xs[2] = xs[1];
      load(16'h0004);
      run(xs[0], 1'b1);
      gen(TYPE_U32, 3);
      xs[1] = xs[0] - 72'sh1;
      load(16'h0003);
      run(xs[2], 1'b1);
      endSim();
   end
endmodule
